// file: shared/mcm_defs.svh
// constants for the command mailbox controller
`ifndef MCM_DEFS_SVH
`define MCM_DEFS_SVH

// ----------------------------------------
// software register offsets (apb bytes)
// ----------------------------------------
`define MCM_OFS_CTRL      8'h00
`define MCM_OFS_PASSWORD  8'h04
`define MCM_OFS_PARAM     8'h08
`define MCM_OFS_STATUS    8'h0c
`define MCM_OFS_IRQ_STAT  8'h10
`define MCM_OFS_IRQ_CLR   8'h14
`define MCM_OFS_IRQ_EN    8'h18
`define MCM_OFS_CMD       8'h1c

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define MCM_CTRL_START    0
`define MCM_IRQ_DONE      0
`define MCM_IRQ_FAIL      1
`define MCM_IRQ_TMO       2
`define MCM_IRQ_GIVEUP    3
`define MCM_IRQ_W         4
`define MCM_RST_CMD       16'hb688
`define MCM_RST_PARAM     16'h0200
`define MCM_RST_PASSWORD  32'h0000_0000

// ----------------------------------------
// device map and block contents
// ----------------------------------------
`define MCM_DEV_BLOCK     16'h1f40
`define MCM_DEV_ECHO      16'h1f54
`define MCM_DEV_STATUS    16'h1f55
`define MCM_BLOCK_LAST    5'h13
`define MCM_WORD_LEN      16'h000c
`define MCM_WORD_DEST     16'h1201
`define MCM_WORD_3        16'h0001
`define MCM_WORD_SETUP17  16'h1f53
`define MCM_WORD_SETUP18  16'h1f54
`define MCM_WORD_SETUP19  16'h1f55
`define MCM_BUSY_CODE     16'h0003

// ----------------------------------------
// timing
// ----------------------------------------
`define MCM_CLK_NS        8
`define MCM_TIMEOUT_NS    1000000000
`define MCM_MAX_RETRY     3

`endif

// file: shared/mcm_pkg.sv
// types for the command mailbox controller
package mcm_pkg;
  typedef enum logic [1:0] {
    MCM_IDLE,
    MCM_WRITE,
    MCM_POLL,
    MCM_ECHO
  } mcm_state_t;
endpackage

// file: rtl/mcm_ctrl.sv
// command mailbox controller: apb slave, drives device register port
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`include "mcm_defs.svh"
module mcm_ctrl
  import mcm_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `MCM_TIMEOUT_NS / `MCM_CLK_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             dev_req,
  output logic             dev_we,
  output logic      [15:0] dev_addr,
  output logic      [15:0] dev_wdata,
  output logic             dev_last,
  input  wire logic        dev_ack,
  input  wire logic [15:0] dev_rdata
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  mcm_state_t                state_reg;
  logic [4:0]                idx_reg;
  logic [1:0]                retry_reg;
  logic [31:0]               cnt_reg;
  logic [15:0]               cmd_reg;
  logic [15:0]               cmd_lat_reg;
  logic [15:0]               param_reg;
  logic [31:0]               pw_reg;
  logic [15:0]               seen_reg;
  logic [15:0]               echo_reg;
  logic [7:0]                result_reg;
  logic                      tmo_flag_reg;
  logic                      giveup_reg;
  logic [`MCM_IRQ_W-1:0]     irq_stat_reg;
  logic [`MCM_IRQ_W-1:0]     irq_en_reg;
  logic [`MCM_IRQ_W-1:0]     irq_set;
  logic [`MCM_IRQ_W-1:0]     irq_clr;
  logic                      wr_acc;
  logic                      start_w;
  logic                      mapped;
  logic                      tmo_hit;

  assign wr_acc  = psel && penable && pready && pwrite;
  assign start_w = wr_acc && (paddr == `MCM_OFS_CTRL)
                   && pwdata[`MCM_CTRL_START] && (state_reg == MCM_IDLE);
  assign tmo_hit = (cnt_reg >= TIMEOUT_CYCLES);
  assign irq_clr = (wr_acc && paddr == `MCM_OFS_IRQ_CLR)
                   ? pwdata[`MCM_IRQ_W-1:0] : '0;

  // ----------------------------------------
  // block word contents
  // ----------------------------------------
  function automatic logic [15:0] block_word(
    input logic [4:0]  i,
    input logic [15:0] cmd,
    input logic [31:0] pw,
    input logic [15:0] param
  );
    case (i)
      5'h00:   block_word = cmd;
      5'h01:   block_word = `MCM_WORD_LEN;
      5'h02:   block_word = `MCM_WORD_DEST;
      5'h03:   block_word = `MCM_WORD_3;
      5'h04:   block_word = pw[31:16];
      5'h05:   block_word = pw[15:0];
      5'h06:   block_word = param;
      5'h11:   block_word = `MCM_WORD_SETUP17;
      5'h12:   block_word = `MCM_WORD_SETUP18;
      5'h13:   block_word = `MCM_WORD_SETUP19;
      default: block_word = 16'h0000;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `MCM_OFS_CTRL, `MCM_OFS_PASSWORD, `MCM_OFS_PARAM, `MCM_OFS_STATUS,
      `MCM_OFS_IRQ_STAT, `MCM_OFS_IRQ_CLR, `MCM_OFS_IRQ_EN,
      `MCM_OFS_CMD: is_mapped = 1'b1;
      default:      is_mapped = 1'b0;
    endcase
  endfunction

  assign mapped = is_mapped(paddr);

  // ----------------------------------------
  // apb slave: one wait-free access phase
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `MCM_OFS_PASSWORD: prdata <= pw_reg;
          `MCM_OFS_PARAM:    prdata <= {16'h0000, param_reg};
          `MCM_OFS_STATUS:   prdata <= {echo_reg, result_reg, 5'h00,
                                        giveup_reg, tmo_flag_reg,
                                        state_reg != MCM_IDLE};
          `MCM_OFS_IRQ_STAT: prdata <= {28'h0000000, irq_stat_reg};
          `MCM_OFS_IRQ_EN:   prdata <= {28'h0000000, irq_en_reg};
          `MCM_OFS_CMD:      prdata <= {16'h0000, cmd_reg};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software-owned settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg    <= `MCM_RST_CMD;
      param_reg  <= `MCM_RST_PARAM;
      pw_reg     <= `MCM_RST_PASSWORD;
      irq_en_reg <= '0;
    end else if (wr_acc) begin
      case (paddr)
        `MCM_OFS_CMD:      cmd_reg    <= pwdata[15:0];
        `MCM_OFS_PARAM:    param_reg  <= pwdata[15:0];
        `MCM_OFS_PASSWORD: pw_reg     <= pwdata;
        `MCM_OFS_IRQ_EN:   irq_en_reg <= pwdata[`MCM_IRQ_W-1:0];
        default:           cmd_reg    <= cmd_reg;
      endcase
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= MCM_IDLE;
      idx_reg      <= 5'h00;
      retry_reg    <= 2'h0;
      cmd_lat_reg  <= 16'h0000;
      seen_reg     <= 16'h0000;
      echo_reg     <= 16'h0000;
      result_reg   <= 8'h00;
      tmo_flag_reg <= 1'b0;
      giveup_reg   <= 1'b0;
    end else begin
      case (state_reg)
        MCM_IDLE: begin
          if (start_w) begin
            state_reg    <= MCM_WRITE;
            idx_reg      <= 5'h00;
            retry_reg    <= 2'h0;
            cmd_lat_reg  <= cmd_reg;
            tmo_flag_reg <= 1'b0;
            giveup_reg   <= 1'b0;
          end
        end
        MCM_WRITE: begin
          if (dev_ack) begin
            if (idx_reg == `MCM_BLOCK_LAST) begin
              state_reg <= MCM_POLL;
            end else begin
              idx_reg <= idx_reg + 5'h01;
            end
          end
        end
        MCM_POLL: begin
          if (dev_ack) begin
            if (dev_rdata == `MCM_BUSY_CODE) begin
              if (tmo_hit) begin
                state_reg    <= MCM_IDLE;
                tmo_flag_reg <= 1'b1;
              end
            end else begin
              seen_reg  <= dev_rdata;
              state_reg <= MCM_ECHO;
            end
          end
        end
        MCM_ECHO: begin
          if (dev_ack) begin
            echo_reg <= dev_rdata;
            if (dev_rdata != cmd_lat_reg) begin
              if (retry_reg < 2'(`MCM_MAX_RETRY)) begin
                state_reg <= MCM_WRITE;
                idx_reg   <= 5'h00;
                retry_reg <= retry_reg + 2'h1;
              end else begin
                state_reg  <= MCM_IDLE;
                giveup_reg <= 1'b1;
              end
            end else begin
              state_reg  <= MCM_IDLE;
              result_reg <= seen_reg[7:0];
            end
          end
        end
        default: state_reg <= MCM_IDLE;
      endcase
    end
  end

  // busy timer, restarts with each poll phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0000_0000;
    end else if (state_reg != MCM_POLL) begin
      cnt_reg <= 32'h0000_0000;
    end else if (!tmo_hit) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // device register port
  // ----------------------------------------
  // one idle cycle between requests keeps issue logic off the ack path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_req   <= 1'b0;
      dev_we    <= 1'b0;
      dev_addr  <= 16'h0000;
      dev_wdata <= 16'h0000;
      dev_last  <= 1'b0;
    end else if (dev_req) begin
      if (dev_ack) begin
        dev_req <= 1'b0;
      end
    end else if (state_reg == MCM_WRITE) begin
      dev_req   <= 1'b1;
      dev_we    <= 1'b1;
      dev_addr  <= `MCM_DEV_BLOCK + {11'h000, idx_reg};
      dev_wdata <= block_word(idx_reg, cmd_lat_reg, pw_reg, param_reg);
      dev_last  <= (idx_reg == `MCM_BLOCK_LAST);
    end else if (state_reg == MCM_POLL || state_reg == MCM_ECHO) begin
      dev_req   <= 1'b1;
      dev_we    <= 1'b0;
      dev_addr  <= (state_reg == MCM_POLL) ? `MCM_DEV_STATUS
                                           : `MCM_DEV_ECHO;
      dev_wdata <= 16'h0000;
      dev_last  <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_comb begin
    irq_set = '0;
    if (state_reg == MCM_ECHO && dev_ack && dev_rdata == cmd_lat_reg) begin
      irq_set[`MCM_IRQ_DONE] = 1'b1;
      irq_set[`MCM_IRQ_FAIL] = (seen_reg[7:0] != 8'h00);
    end
    if (state_reg == MCM_POLL && dev_ack && tmo_hit
        && dev_rdata == `MCM_BUSY_CODE) begin
      irq_set[`MCM_IRQ_TMO] = 1'b1;
    end
    if (state_reg == MCM_ECHO && dev_ack && dev_rdata != cmd_lat_reg
        && retry_reg == 2'(`MCM_MAX_RETRY)) begin
      irq_set[`MCM_IRQ_GIVEUP] = 1'b1;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq         <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      irq          <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_last_word;
    dev_req && dev_we && dev_last |-> dev_addr == 16'h1f53;
  endproperty
  a_last_word: assert property (p_last_word)
    else $error("last block word not at word19");

  property p_code_word;
    dev_req && dev_we && dev_addr == 16'h1f40 |-> dev_wdata == cmd_lat_reg;
  endproperty
  a_code_word: assert property (p_code_word)
    else $error("word0 is not the command code");

  property p_len_word;
    dev_req && dev_we && dev_addr == 16'h1f41 |-> dev_wdata == 16'h000c;
  endproperty
  a_len_word: assert property (p_len_word)
    else $error("word1 length is not twelve");

  property p_dest_word;
    dev_req && dev_we && dev_addr == 16'h1f42 |-> dev_wdata == 16'h1201;
  endproperty
  a_dest_word: assert property (p_dest_word)
    else $error("word2 destination wrong");

  property p_one_word;
    dev_req && dev_we && dev_addr == 16'h1f43 |-> dev_wdata == 16'h0001;
  endproperty
  a_one_word: assert property (p_one_word)
    else $error("word3 is not one");

  property p_pw_word;
    dev_req && dev_we && dev_addr == 16'h1f44 |-> dev_wdata == pw_reg[31:16];
  endproperty
  a_pw_word: assert property (p_pw_word)
    else $error("word4 is not password high half");

  property p_param_word;
    dev_req && dev_we && dev_addr == 16'h1f46 |-> dev_wdata == param_reg;
  endproperty
  a_param_word: assert property (p_param_word)
    else $error("word6 is not the parameter");

  property p_zero_words;
    dev_req && dev_we && dev_addr >= 16'h1f47 && dev_addr <= 16'h1f50
      |-> dev_wdata == 16'h0000;
  endproperty
  a_zero_words: assert property (p_zero_words)
    else $error("unused word not zero");

  property p_setup_words;
    dev_req && dev_we && dev_addr == 16'h1f52 |-> dev_wdata == 16'h1f54;
  endproperty
  a_setup_words: assert property (p_setup_words)
    else $error("word18 setup constant wrong");

  property p_block_start;
    $rose(dev_req) && dev_we && dev_addr == 16'h1f40
      |-> $past(state_reg) != MCM_POLL;
  endproperty
  a_block_start: assert property (p_block_start)
    else $error("block write started from poll");

  property p_repoll;
    state_reg == MCM_POLL && dev_ack && dev_rdata == 16'h0003 && !tmo_hit
      |=> !dev_req ##1 dev_req && !dev_we && dev_addr == 16'h1f55;
  endproperty
  a_repoll: assert property (p_repoll)
    else $error("busy status not polled again");

  property p_timeout;
    state_reg == MCM_POLL && dev_ack && dev_rdata == 16'h0003 && tmo_hit
      |=> state_reg == MCM_IDLE && tmo_flag_reg ##1 irq_stat_reg[2];
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("poll did not stop at timeout");

  property p_resubmit;
    state_reg == MCM_ECHO && dev_ack && dev_rdata != cmd_lat_reg
      && retry_reg < 2'h3
      |=> ##1 dev_req && dev_we && dev_addr == 16'h1f40;
  endproperty
  a_resubmit: assert property (p_resubmit)
    else $error("echo mismatch not resubmitted");

  property p_result;
    state_reg == MCM_ECHO && dev_ack && dev_rdata == cmd_lat_reg
      |=> state_reg == MCM_IDLE && result_reg == seen_reg[7:0];
  endproperty
  a_result: assert property (p_result)
    else $error("result byte not taken from status");

  c_success: cover property (state_reg == MCM_ECHO && dev_ack
                             && dev_rdata == cmd_lat_reg
                             && seen_reg[7:0] == 8'h00);
  c_fail:    cover property (irq_set[`MCM_IRQ_FAIL]);
  c_retry:   cover property (state_reg == MCM_ECHO && dev_ack
                             && dev_rdata != cmd_lat_reg);
  c_tmo:     cover property (irq_set[`MCM_IRQ_TMO]);

endmodule

// file: tb/mcm_dev_model.sv
// device side of the command mailbox register port
`timescale 1ns/10ps
module mcm_dev_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        dev_req,
  input  wire logic        dev_we,
  input  wire logic [15:0] dev_addr,
  input  wire logic [15:0] dev_wdata,
  input  wire logic        dev_last,
  output logic             dev_ack,
  output logic      [15:0] dev_rdata,
  input  wire logic [7:0]  ack_dly,
  input  wire logic [15:0] busy_n,
  input  wire logic [7:0]  bad_n,
  input  wire logic [31:0] good_pw
);
  logic [15:0] blk [20];
  logic [15:0] echo_reg;
  logic [7:0]  res_reg;
  int          wait_cnt, busy_left, bad_used, widx, nsub, bad_ord;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_ack   <= 1'b0;
      dev_rdata <= 16'h0000;
      wait_cnt  <= 0;
      busy_left <= 0;
      bad_used  <= 0;
      widx      <= 0;
      nsub      <= 0;
      bad_ord   <= 0;
      echo_reg  <= 16'h0000;
      res_reg   <= 8'h00;
    end else begin
      dev_ack <= 1'b0;
      if (dev_req && !dev_ack) begin
        if (wait_cnt < ack_dly) begin
          wait_cnt <= wait_cnt + 1;
        end else begin
          wait_cnt <= 0;
          dev_ack  <= 1'b1;
          if (dev_we) begin
            // one block from the first register
            if (dev_addr != 16'h1f40 + widx[15:0] ||
                dev_last != (widx == 19)) begin
              bad_ord <= bad_ord + 1;
            end
            blk[widx] <= dev_wdata;
            widx      <= (widx == 19) ? 0 : widx + 1;
            if (dev_last) begin
              nsub      <= nsub + 1;
              busy_left <= busy_n;
              res_reg <= busy_left > 0 ? 8'h9e :
                {blk[4], blk[5]} != good_pw ? 8'h01 :
                blk[0] != 16'hb688 ? 8'h13 : 8'h00;
              echo_reg <= (bad_used < bad_n) ? ~blk[0] : blk[0];
              if (bad_used < bad_n) begin
                bad_used <= bad_used + 1;
              end
            end
          end else if (dev_addr == 16'h1f55) begin
            dev_rdata <= busy_left > 0 ? 16'h0003 : {8'h12, res_reg};
            if (busy_left > 0) begin
              busy_left <= busy_left - 1;
            end
          end else begin
            dev_rdata <= dev_addr == 16'h1f54 ? echo_reg : 16'h0000;
          end
        end
      end else begin
        // stale read data never looks valid
        dev_rdata <= ~dev_rdata;
        if (bad_n == 8'h00) begin
          bad_used <= 0;
        end
      end
    end
  end
endmodule

// file: tb/test_mcm_ctrl.sv
// self-checking bench for the command mailbox controller
`timescale 1ns/10ps
module test_mcm_ctrl;
  localparam logic [31:0] GOOD_PW = 32'h5077_3537;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        er, dev_req, dev_we, dev_last, dev_ack;
  logic [7:0]  paddr, ack_dly, bad_n;
  logic [31:0] pwdata, prdata, rd, ist, sts;
  logic [15:0] dev_addr, dev_wdata, dev_rdata, busy_n;
  logic [3:0]  en;
  int          error_cnt, check_count, cyc, j;
  logic [7:0]  ofs [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c};
  logic [31:0] rv  [6] = '{32'h0, 32'h200, 32'h0, 32'h0, 32'h0, 32'hb688};

  mcm_ctrl #(.TIMEOUT_CYCLES(50)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .dev_req(dev_req), .dev_we(dev_we), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_last(dev_last), .dev_ack(dev_ack),
    .dev_rdata(dev_rdata));
  mcm_dev_model dev (.pclk(pclk), .presetn(presetn), .dev_req(dev_req),
    .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_last(dev_last), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
    .ack_dly(ack_dly), .busy_n(busy_n), .bad_n(bad_n), .good_pw(GOOD_PW));

  always #4 pclk = ~pclk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog: whole run is a few thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      $display("MISMATCH %0t watchdog expired", $time);
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] g, x, input string m);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask

  // release then one idle edge, so no signal is driven twice at once
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ends once pready is high; only the watchdog ends it if pready never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [15:0] exp_word(input int i,
    input logic [15:0] c, input logic [31:0] pw, input logic [15:0] pr);
    case (i)
      0: return c;
      1: return 16'h000c;
      2: return 16'h1201;
      3: return 16'h0001;
      4: return pw[31:16];
      5: return pw[15:0];
      6: return pr;
      17: return 16'h1f53;
      18: return 16'h1f54;
      19: return 16'h1f55;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic run(input logic [15:0] cm, input logic [31:0] pw,
    input logic [15:0] pr, input logic [7:0] res, input logic [3:0] ie,
    input int ns);
    int n0, k;
    n0 = dev.nsub;
    apb(1'b1, 8'h1c, {16'h0, cm});
    apb(1'b1, 8'h04, pw);
    apb(1'b1, 8'h08, {16'h0, pr});
    apb(1'b1, 8'h00, 32'h1);
    // second start lands while busy and must be dropped
    apb(1'b1, 8'h00, 32'h1);
    for (k = 0; k < 3000; k++) begin
      apb(1'b0, 8'h10, 32'h0);
      ist = rd;
      apb(1'b0, 8'h0c, 32'h0);
      sts = rd;
      if (ist !== 32'h0 && sts[0] === 1'b0) break;
    end
    chk(dev.nsub - n0, ns, "submissions");
    for (k = 0; k < 20; k++) begin
      chk(dev.blk[k], exp_word(k, cm, pw, pr), "block word");
    end
    chk(ist, {28'h0, ie}, "irq status");
    chk(sts[2:0], {ie[3:2], 1'b0}, "status flags");
    if (ie[0]) chk(sts[31:8], {cm, res}, "echo and result");
    chk(irq, |(ie & en), "irq level");
    apb(1'b1, 8'h14, 32'hf);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq clear");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    ack_dly = 8'h00;
    busy_n  = 16'h0002;
    bad_n   = 8'h00;
    j = $urandom(35);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (j = 0; j < 6; j++) begin
      apb(1'b0, ofs[j], 32'h0);
      chk(rd, rv[j], "reset value");
    end
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0, "read-only status");
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    en = 4'hf;
    apb(1'b1, 8'h18, 32'hf);
    for (j = 0; j < 4; j++) begin
      ack_dly <= 8'($urandom_range(3));
      busy_n  <= 16'($urandom_range(4));
      run(16'hb688, GOOD_PW, j == 0 ? 16'h0200 : 16'($urandom), 8'h00, 4'h1, 1);
    end
    run(16'hb688, GOOD_PW ^ ($urandom | 32'h1), 16'h0200, 8'h01, 4'h3, 1);
    run(16'hb688 ^ 16'($urandom_range(1, 65535)), GOOD_PW, 16'h0200, 8'h13, 4'h3, 1);
    en = 4'h0;
    apb(1'b1, 8'h18, 32'h0);
    run(16'hb688, GOOD_PW, 16'h0200, 8'h00, 4'h1, 1);
    en = 4'hf;
    apb(1'b1, 8'h18, 32'hf);
    bad_n <= 8'h01;
    run(16'hb688, GOOD_PW, 16'h0200, 8'h00, 4'h1, 2);
    bad_n <= 8'h00;
    repeat (2) @(posedge pclk);
    bad_n <= 8'h08;
    run(16'hb688, GOOD_PW, 16'h0200, 8'h00, 4'h8, 4);
    bad_n <= 8'h00;
    repeat (2) @(posedge pclk);
    busy_n <= 16'd1000;
    run(16'hb688, GOOD_PW, 16'h0200, 8'h00, 4'h4, 1);
    busy_n <= 16'd2;
    run(16'hb688, GOOD_PW, 16'h0200, 8'h9e, 4'h3, 1);
    chk(dev.bad_ord, 32'h0, "block order");
    stop_test();
  end
endmodule
